//--- verilog/csb_exec.sv
`timescale 1ns/10ps
// Summary of operation
// - register compare: dest minus source, result dropped, five flags set, one cycle.
// - compare with carry: dest minus source minus carry, flags set, one cycle.
// - immediate compare: dest minus constant, nothing written back, flags set, one cycle.
// - skip on clear register bit: pc plus 2 or 3, flags kept, 1-3 cycles.
// - skip on set register bit: pc plus 2 or 3, flags kept, 1-3 cycles.
// - skip on clear io bit: pc plus 2 or 3, flags kept, 1-3 cycles.
// - skip on set io bit: pc plus 2 or 3, flags kept, 1-3 cycles.
// - branch if chosen flag is one: pc plus offset plus one, 1-2 cycles.
// - branch if chosen flag is zero: pc plus offset plus one, 1-2 cycles.
// - branch on zero flag set, flags kept, one or two cycles.
// - branch on zero flag clear, pc plus offset plus one, flags kept.
// - branch on carry set, one or two cycles, no flag change.
// - branch on carry clear, one or two cycles, no flag change.
// - unsigned same-or-higher branch when carry is zero, flags kept.
// - unsigned lower branch when carry is one, 1-2 cycles, flags kept.
// - branch on negative flag set, flags kept, one or two cycles.
// - branch on negative flag clear, flags kept, one or two cycles.
// - signed greater-or-equal branch when negative xor overflow is zero.
module csb_exec #(
  parameter int unsigned PC_W = csb_pkg::PC_W
) (
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // ahb-lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata,
  // execution state
  output logic                  exec_busy,
  output logic [PC_W-1:0]       pc_value,
  output logic [csb_pkg::DATA_W-1:0] flag_value
);

  localparam int unsigned DW = csb_pkg::DATA_W;
  localparam int unsigned SW = csb_pkg::SEL_W;
  localparam int unsigned OW = csb_pkg::OFS_W;
  localparam int unsigned CW = csb_pkg::CYC_W;
  localparam int unsigned AW = csb_pkg::ADDR_W;

  // word-aligned register hit, shared by read and write paths
  function automatic logic reg_hit(input logic [AW-1:0] addr, input logic [AW-1:0] offs);
    reg_hit = (addr == offs);
  endfunction

  // bus tracking state
  logic          dphase_q, dphase_d;
  logic          dwrite_q, dwrite_d;
  logic [AW-1:0] daddr_q, daddr_d;
  logic          rd_done_q, rd_done_d;
  logic [31:0]   hrdata_q, hrdata_d;

  // software-visible operand and program state
  logic [DW-1:0]   dest_q, dest_d;
  logic [DW-1:0]   src_q, src_d;
  logic [DW-1:0]   io_q, io_d;
  logic [SW-1:0]   bit_q, bit_d;
  logic            two_word_q, two_word_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic [DW-1:0]   flags_q, flags_d;
  logic [OW-1:0]   ofs_q, ofs_d;
  logic [SW-1:0]   fsel_q, fsel_d;

  // execution state
  csb_pkg::csb_state_t state_q, state_d;
  csb_pkg::csb_op_t    op_q, op_d;
  logic [CW-1:0]       cnt_q, cnt_d;
  logic [CW-1:0]       cyc_q, cyc_d;
  logic                taken_q, taken_d;
  logic                bad_q, bad_d;

  // combinational helpers
  logic            accept;
  logic            busy;
  logic            wr_fire;
  logic            start;
  logic [31:0]     rd_mux;
  logic            is_compare;
  logic            is_skip;
  logic            legal;
  logic            taken;
  logic            with_carry;
  logic [DW-1:0]   sub_value;
  logic            cmp_z, cmp_n, cmp_v, cmp_c, cmp_h;
  logic [CW-1:0]   cycles;
  logic [PC_W-1:0] pc_next;
  logic [PC_W-1:0] ofs_ext;
  csb_pkg::csb_op_t new_op;

  assign busy      = (state_q != csb_pkg::ST_IDLE);
  assign accept    = hsel & hready & htrans[csb_pkg::HTRANS_ACTIVE];
  // writes and reads wait while an instruction is in flight
  assign hreadyout = ~dphase_q | (dwrite_q ? ~busy : rd_done_q);
  assign wr_fire   = dphase_q & dwrite_q & ~busy;
  assign start     = wr_fire & reg_hit(daddr_q, csb_pkg::REG_COMMAND);
  assign new_op    = csb_pkg::csb_op_t'(hwdata[csb_pkg::CMD_OP_LSB +: csb_pkg::CMD_OP_W]);
  assign hresp     = csb_pkg::HRESP_OKAY;
  assign hrdata    = hrdata_q;
  assign exec_busy = busy;
  assign pc_value  = pc_q;
  assign flag_value = flags_q;

  // register or io bit test for skips, flag test for branches
  csb_condition u_cond (
    .op         (op_q),
    .flags      (flags_q),
    .src_value  (src_q),
    .io_value   (io_q),
    .bit_sel    (bit_q),
    .flag_sel   (fsel_q),
    .is_compare (is_compare),
    .is_skip    (is_skip),
    .legal      (legal),
    .taken      (taken)
  );

  // immediate compare takes the constant from the source field
  always_comb begin
    with_carry = (op_q == csb_pkg::OP_COMPARE_WITH_CARRY_IN);
    sub_value  = src_q;
  end

  // subtractor with flag logic
  csb_compare #(
    .DATA_W (DW)
  ) u_cmp (
    .dest_value (dest_q),
    .sub_value  (sub_value),
    .carry_in   (flags_q[csb_pkg::FLG_C]),
    .with_carry (with_carry),
    .zero_in    (flags_q[csb_pkg::FLG_Z]),
    .zero_out   (cmp_z),
    .neg_out    (cmp_n),
    .ovf_out    (cmp_v),
    .carry_out  (cmp_c),
    .half_out   (cmp_h)
  );

  // next pc and cycle count of the instruction in flight
  always_comb begin
    ofs_ext = {{(PC_W-OW){ofs_q[OW-1]}}, ofs_q};
    pc_next = pc_q + csb_pkg::STEP_NEXT;
    cycles  = csb_pkg::CYC_ONE;
    if (is_skip && taken) begin
      // a skipped two-word instruction costs one more cycle
      pc_next = pc_q + (two_word_q ? csb_pkg::STEP_SKIP2 : csb_pkg::STEP_SKIP1);
      cycles  = two_word_q ? csb_pkg::CYC_THREE : csb_pkg::CYC_TWO;
    end else if (!is_skip && !is_compare && taken) begin
      pc_next = pc_q + ofs_ext + csb_pkg::STEP_NEXT;
      cycles  = csb_pkg::CYC_TWO;
    end
    // untaken branch or skip falls through to pc plus one
  end

  // ahb-lite address and data phase tracking
  always_comb begin
    dphase_d  = dphase_q;
    dwrite_d  = dwrite_q;
    daddr_d   = daddr_q;
    rd_done_d = rd_done_q;
    hrdata_d  = hrdata_q;
    if (dphase_q && hreadyout) begin
      dphase_d  = 1'b0;
      rd_done_d = 1'b0;
    end
    if (dphase_q && !dwrite_q && !busy && !rd_done_q) begin
      // one wait state so that read data comes from a flop
      hrdata_d  = rd_mux;
      rd_done_d = 1'b1;
    end
    if (accept) begin
      dphase_d  = 1'b1;
      dwrite_d  = hwrite & (hsize == csb_pkg::HSIZE_WORD);
      daddr_d   = haddr[AW-1:0];
      rd_done_d = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dphase_q  <= 1'b0;
      dwrite_q  <= 1'b0;
      daddr_q   <= '0;
      rd_done_q <= 1'b0;
      hrdata_q  <= 32'h00000000;
    end else begin
      dphase_q  <= dphase_d;
      dwrite_q  <= dwrite_d;
      daddr_q   <= daddr_d;
      rd_done_q <= rd_done_d;
      hrdata_q  <= hrdata_d;
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    rd_mux = 32'h00000000;
    if (reg_hit(daddr_q, csb_pkg::REG_OPERANDS)) begin
      rd_mux[csb_pkg::OPND_DEST_LSB +: DW] = dest_q;
      rd_mux[csb_pkg::OPND_SRC_LSB +: DW]  = src_q;
      rd_mux[csb_pkg::OPND_IO_LSB +: DW]   = io_q;
      rd_mux[csb_pkg::OPND_BIT_LSB +: SW]  = bit_q;
      rd_mux[csb_pkg::OPND_TWO_WORD]       = two_word_q;
    end else if (reg_hit(daddr_q, csb_pkg::REG_PC)) begin
      rd_mux[PC_W-1:0] = pc_q;
    end else if (reg_hit(daddr_q, csb_pkg::REG_FLAGS)) begin
      rd_mux[DW-1:0] = flags_q;
    end else if (reg_hit(daddr_q, csb_pkg::REG_BRANCH)) begin
      rd_mux[csb_pkg::BR_OFS_LSB +: OW] = ofs_q;
      rd_mux[csb_pkg::BR_SEL_LSB +: SW] = fsel_q;
    end else if (reg_hit(daddr_q, csb_pkg::REG_COMMAND)) begin
      rd_mux[csb_pkg::CMD_OP_LSB +: csb_pkg::CMD_OP_W] = op_q;
      rd_mux[csb_pkg::CMD_BUSY]                        = busy;
      rd_mux[csb_pkg::CMD_TAKEN]                       = taken_q;
      rd_mux[csb_pkg::CMD_CYC_LSB +: CW]               = cyc_q;
      rd_mux[csb_pkg::CMD_BAD]                         = bad_q;
    end
  end

  // register file: software writes, execution commits pc and flags
  always_comb begin
    dest_d     = dest_q;
    src_d      = src_q;
    io_d       = io_q;
    bit_d      = bit_q;
    two_word_d = two_word_q;
    pc_d       = pc_q;
    flags_d    = flags_q;
    ofs_d      = ofs_q;
    fsel_d     = fsel_q;
    if (wr_fire && reg_hit(daddr_q, csb_pkg::REG_OPERANDS)) begin
      dest_d     = hwdata[csb_pkg::OPND_DEST_LSB +: DW];
      src_d      = hwdata[csb_pkg::OPND_SRC_LSB +: DW];
      io_d       = hwdata[csb_pkg::OPND_IO_LSB +: DW];
      bit_d      = hwdata[csb_pkg::OPND_BIT_LSB +: SW];
      two_word_d = hwdata[csb_pkg::OPND_TWO_WORD];
    end
    if (wr_fire && reg_hit(daddr_q, csb_pkg::REG_PC)) begin
      pc_d = hwdata[PC_W-1:0];
    end
    if (wr_fire && reg_hit(daddr_q, csb_pkg::REG_FLAGS)) begin
      flags_d = hwdata[DW-1:0];
    end
    if (wr_fire && reg_hit(daddr_q, csb_pkg::REG_BRANCH)) begin
      ofs_d  = hwdata[csb_pkg::BR_OFS_LSB +: OW];
      fsel_d = hwdata[csb_pkg::BR_SEL_LSB +: SW];
    end
    // no bus write can land here: the bus stalls while busy
    if (state_q == csb_pkg::ST_EXEC) begin
      pc_d = pc_next;
      if (is_compare) begin
        // only compares touch flags; skips and branches leave them
        flags_d[csb_pkg::FLG_Z] = cmp_z;
        flags_d[csb_pkg::FLG_N] = cmp_n;
        flags_d[csb_pkg::FLG_V] = cmp_v;
        flags_d[csb_pkg::FLG_C] = cmp_c;
        flags_d[csb_pkg::FLG_H] = cmp_h;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dest_q     <= '0;
      src_q      <= '0;
      io_q       <= '0;
      bit_q      <= '0;
      two_word_q <= 1'b0;
      pc_q       <= csb_pkg::PC_RST;
      flags_q    <= csb_pkg::FLAGS_RST;
      ofs_q      <= '0;
      fsel_q     <= '0;
    end else begin
      dest_q     <= dest_d;
      src_q      <= src_d;
      io_q       <= io_d;
      bit_q      <= bit_d;
      two_word_q <= two_word_d;
      pc_q       <= pc_d;
      flags_q    <= flags_d;
      ofs_q      <= ofs_d;
      fsel_q     <= fsel_d;
    end
  end

  // sequencer: one exec cycle, then hold for the rest of the count
  always_comb begin
    state_d = state_q;
    op_d    = op_q;
    cnt_d   = cnt_q;
    cyc_d   = cyc_q;
    taken_d = taken_q;
    bad_d   = bad_q;
    unique case (state_q)
      csb_pkg::ST_IDLE: begin
        if (start) begin
          op_d    = new_op;
          state_d = csb_pkg::ST_EXEC;
        end
      end
      csb_pkg::ST_EXEC: begin
        // an unknown opcode raises the bad bit; pc still steps by one
        bad_d   = ~legal;
        taken_d = taken & legal;
        cyc_d   = cycles;
        cnt_d   = cycles - csb_pkg::CYC_ONE;
        state_d = (legal && cycles != csb_pkg::CYC_ONE) ? csb_pkg::ST_HOLD
                                                        : csb_pkg::ST_IDLE;
      end
      csb_pkg::ST_HOLD: begin
        cnt_d = cnt_q - csb_pkg::CYC_ONE;
        if (cnt_q == csb_pkg::CYC_ONE) begin
          state_d = csb_pkg::ST_IDLE;
        end
      end
      default: state_d = csb_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= csb_pkg::ST_IDLE;
      op_q    <= csb_pkg::OP_COMPARE_REGISTERS;
      cnt_q   <= '0;
      cyc_q   <= '0;
      taken_q <= 1'b0;
      bad_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q    <= op_d;
      cnt_q   <= cnt_d;
      cyc_q   <= cyc_d;
      taken_q <= taken_d;
      bad_q   <= bad_d;
    end
  end

endmodule

//--- verilog/csb_pkg.sv
package csb_pkg;

  // data path widths
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned PC_W     = 16;
  localparam int unsigned OFS_W    = 7;
  localparam int unsigned SEL_W    = 3;
  localparam int unsigned CYC_W    = 2;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned HALF_BIT = 3;

  // register byte offsets
  localparam logic [ADDR_W-1:0] REG_OPERANDS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_PC       = 8'h04;
  localparam logic [ADDR_W-1:0] REG_FLAGS    = 8'h08;
  localparam logic [ADDR_W-1:0] REG_BRANCH   = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_COMMAND  = 8'h10;

  // field positions
  localparam int unsigned OPND_DEST_LSB = 0;
  localparam int unsigned OPND_SRC_LSB  = 8;
  localparam int unsigned OPND_IO_LSB   = 16;
  localparam int unsigned OPND_BIT_LSB  = 24;
  localparam int unsigned OPND_TWO_WORD = 28;
  localparam int unsigned BR_OFS_LSB    = 0;
  localparam int unsigned BR_SEL_LSB    = 8;
  localparam int unsigned CMD_OP_LSB    = 0;
  localparam int unsigned CMD_OP_W      = 5;
  localparam int unsigned CMD_BUSY      = 8;
  localparam int unsigned CMD_TAKEN     = 9;
  localparam int unsigned CMD_CYC_LSB   = 10;
  localparam int unsigned CMD_BAD       = 12;

  // flag positions inside the flag register
  localparam logic [SEL_W-1:0] FLG_C = 3'h0;
  localparam logic [SEL_W-1:0] FLG_Z = 3'h1;
  localparam logic [SEL_W-1:0] FLG_N = 3'h2;
  localparam logic [SEL_W-1:0] FLG_V = 3'h3;
  localparam logic [SEL_W-1:0] FLG_H = 3'h5;

  // reset values and steps
  localparam logic [PC_W-1:0]   PC_RST     = 16'h0000;
  localparam logic [DATA_W-1:0] FLAGS_RST  = 8'h00;
  localparam logic [PC_W-1:0]   STEP_NEXT  = 16'h0001;
  localparam logic [PC_W-1:0]   STEP_SKIP1 = 16'h0002;
  localparam logic [PC_W-1:0]   STEP_SKIP2 = 16'h0003;
  localparam logic [CYC_W-1:0]  CYC_ONE    = 2'h1;
  localparam logic [CYC_W-1:0]  CYC_TWO    = 2'h2;
  localparam logic [CYC_W-1:0]  CYC_THREE  = 2'h3;

  // bus constants
  localparam int unsigned HTRANS_ACTIVE = 1;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;
  localparam logic        HRESP_OKAY    = 1'h0;

  typedef enum logic [4:0] {
    OP_COMPARE_REGISTERS      = 5'b00000,
    OP_COMPARE_WITH_CARRY_IN  = 5'b00001,
    OP_COMPARE_IMMEDIATE      = 5'b00010,
    OP_SKIP_REG_BIT_CLEAR     = 5'b00011,
    OP_SKIP_REG_BIT_SET       = 5'b00100,
    OP_SKIP_IO_BIT_CLEAR      = 5'b00101,
    OP_SKIP_IO_BIT_SET        = 5'b00110,
    OP_BRANCH_FLAG_SET        = 5'b00111,
    OP_BRANCH_FLAG_CLEAR      = 5'b01000,
    OP_BRANCH_EQUAL           = 5'b01001,
    OP_BRANCH_NOT_EQUAL       = 5'b01010,
    OP_BRANCH_CARRY_SET       = 5'b01011,
    OP_BRANCH_CARRY_CLEAR     = 5'b01100,
    OP_BRANCH_SAME_OR_HIGHER  = 5'b01101,
    OP_BRANCH_LOWER           = 5'b01110,
    OP_BRANCH_MINUS           = 5'b01111,
    OP_BRANCH_PLUS            = 5'b10000,
    OP_BRANCH_SIGNED_GE       = 5'b10001
  } csb_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_HOLD = 2'b10
  } csb_state_t;

endpackage

//--- verilog/csb_compare.sv
`timescale 1ns/10ps
module csb_compare #(
  parameter int unsigned DATA_W = csb_pkg::DATA_W
) (
  // operands
  input  wire logic [DATA_W-1:0] dest_value,
  input  wire logic [DATA_W-1:0] sub_value,
  input  wire logic              carry_in,
  input  wire logic              with_carry,
  input  wire logic              zero_in,
  // resulting flags
  output logic                   zero_out,
  output logic                   neg_out,
  output logic                   ovf_out,
  output logic                   carry_out,
  output logic                   half_out
);

  logic [DATA_W-1:0] diff;
  logic              bin;

  // difference is only looked at, never written back
  always_comb begin
    bin       = with_carry & carry_in;
    diff      = dest_value - sub_value - DATA_W'(bin);
    neg_out   = diff[DATA_W-1];
    ovf_out   = (dest_value[DATA_W-1] & ~sub_value[DATA_W-1] & ~diff[DATA_W-1])
              | (~dest_value[DATA_W-1] & sub_value[DATA_W-1] & diff[DATA_W-1]);
    carry_out = (~dest_value[DATA_W-1] & sub_value[DATA_W-1])
              | (sub_value[DATA_W-1] & diff[DATA_W-1])
              | (diff[DATA_W-1] & ~dest_value[DATA_W-1]);
    half_out  = (~dest_value[csb_pkg::HALF_BIT] & sub_value[csb_pkg::HALF_BIT])
              | (sub_value[csb_pkg::HALF_BIT] & diff[csb_pkg::HALF_BIT])
              | (diff[csb_pkg::HALF_BIT] & ~dest_value[csb_pkg::HALF_BIT]);
    // chained compare keeps zero only if the earlier byte was zero too
    zero_out  = (diff == '0) & (~with_carry | zero_in);
  end

endmodule

//--- verilog/csb_condition.sv
`timescale 1ns/10ps
module csb_condition (
  // instruction and operands
  input  wire csb_pkg::csb_op_t                   op,
  input  wire logic [csb_pkg::DATA_W-1:0]         flags,
  input  wire logic [csb_pkg::DATA_W-1:0]         src_value,
  input  wire logic [csb_pkg::DATA_W-1:0]         io_value,
  input  wire logic [csb_pkg::SEL_W-1:0]          bit_sel,
  input  wire logic [csb_pkg::SEL_W-1:0]          flag_sel,
  // decode results
  output logic                                    is_compare,
  output logic                                    is_skip,
  output logic                                    legal,
  output logic                                    taken
);

  logic sel_flag;
  logic reg_bit;
  logic io_bit;

  // one test per opcode; codes above the last are illegal
  always_comb begin
    sel_flag   = flags[flag_sel];
    reg_bit    = src_value[bit_sel];
    io_bit     = io_value[bit_sel];
    is_compare = 1'b0;
    is_skip    = 1'b0;
    legal      = 1'b1;
    taken      = 1'b0;
    unique case (op)
      csb_pkg::OP_COMPARE_REGISTERS,
      csb_pkg::OP_COMPARE_WITH_CARRY_IN,
      csb_pkg::OP_COMPARE_IMMEDIATE:     is_compare = 1'b1;
      csb_pkg::OP_SKIP_REG_BIT_CLEAR:    begin is_skip = 1'b1; taken = ~reg_bit; end
      csb_pkg::OP_SKIP_REG_BIT_SET:      begin is_skip = 1'b1; taken = reg_bit; end
      csb_pkg::OP_SKIP_IO_BIT_CLEAR:     begin is_skip = 1'b1; taken = ~io_bit; end
      csb_pkg::OP_SKIP_IO_BIT_SET:       begin is_skip = 1'b1; taken = io_bit; end
      csb_pkg::OP_BRANCH_FLAG_SET:       taken = sel_flag;
      csb_pkg::OP_BRANCH_FLAG_CLEAR:     taken = ~sel_flag;
      csb_pkg::OP_BRANCH_EQUAL:          taken = flags[csb_pkg::FLG_Z];
      csb_pkg::OP_BRANCH_NOT_EQUAL:      taken = ~flags[csb_pkg::FLG_Z];
      csb_pkg::OP_BRANCH_CARRY_SET:      taken = flags[csb_pkg::FLG_C];
      csb_pkg::OP_BRANCH_CARRY_CLEAR:    taken = ~flags[csb_pkg::FLG_C];
      csb_pkg::OP_BRANCH_SAME_OR_HIGHER: taken = ~flags[csb_pkg::FLG_C];
      csb_pkg::OP_BRANCH_LOWER:          taken = flags[csb_pkg::FLG_C];
      csb_pkg::OP_BRANCH_MINUS:          taken = flags[csb_pkg::FLG_N];
      csb_pkg::OP_BRANCH_PLUS:           taken = ~flags[csb_pkg::FLG_N];
      csb_pkg::OP_BRANCH_SIGNED_GE:
        taken = ~(flags[csb_pkg::FLG_N] ^ flags[csb_pkg::FLG_V]);
      default:                           legal = 1'b0;
    endcase
  end

endmodule

//--- sim/csb_exec_asserts.sv
`timescale 1ns/10ps
module csb_exec_asserts #(
  parameter int unsigned PC_W = 16
) (
  // clock and reset
  input wire logic            hclk,
  input wire logic            hresetn,
  // bus
  input wire logic            hsel,
  input wire logic [31:0]     haddr,
  input wire logic [1:0]      htrans,
  input wire logic            hwrite,
  input wire logic [2:0]      hsize,
  input wire logic [31:0]     hwdata,
  input wire logic            hready,
  input wire logic            hreadyout,
  input wire logic            hresp,
  // execution state
  input wire logic            exec_busy,
  input wire logic [PC_W-1:0] pc_value,
  input wire logic [7:0]      flag_value
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  logic wr_d;
  logic wr_q;
  logic cmd_d;
  logic cmd_q;
  assign take = hsel && hready && htrans[1];
  // data phase tracking; only word writes ever land
  always_comb begin
    wr_d = hready ? (take && hwrite && hsize == 3'h2) : wr_q;
    cmd_d = hready ? (take && hwrite && haddr[7:0] == 8'h10) : cmd_q;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      cmd_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      cmd_q <= cmd_d;
    end
  end
  sequence s_read;
    take && !hwrite && !exec_busy;
  endsequence
  sequence s_launch;
    cmd_q && hreadyout;
  endsequence
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  chk_read_wait: assert property (take && !hwrite |=> !hreadyout)
    else $error("read answered without wait");
  chk_read_done: assert property (s_read ##1 (!exec_busy)[*2] |-> hreadyout)
    else $error("idle read late");
  chk_write_fast: assert property (take && hwrite && !exec_busy ##1 !exec_busy |-> hreadyout)
    else $error("idle write stalled");
  chk_cmp_cycle: assert property ((s_launch and (hwdata[4:0] <= 5'h02))
    |=> exec_busy ##1 !exec_busy) else $error("compare not one cycle");
  chk_branch_cycle: assert property ((s_launch and (hwdata[4:0] inside {[5'h07:5'h11]}))
    |=> exec_busy ##2 !exec_busy) else $error("branch over two cycles");
  chk_busy_bound: assert property ($rose(exec_busy) |-> ##[1:3] !exec_busy)
    else $error("busy over three cycles");
  chk_state_cause: assert property ($changed(pc_value) || $changed(flag_value)
    |-> $past(exec_busy) || $past(wr_q && hreadyout)) else $error("state changed idle");
  chk_pc_hold: assert property ($past(exec_busy, 2) && $past(exec_busy)
    |-> $stable(pc_value) && $stable(flag_value)) else $error("late state change");
endmodule
bind csb_exec csb_exec_asserts #(.PC_W(PC_W)) csb_exec_asserts_i (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .exec_busy(exec_busy), .pc_value(pc_value), .flag_value(flag_value));

//--- sim/csb_ahb_host.sv
`timescale 1ns/10ps
module csb_ahb_host (
  // clock and answer
  input wire logic         hclk,
  input wire logic         hready,
  input wire logic [31:0]  hrdata,
  // request
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  // idle bus at time zero, word size always
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // call right after a rising edge; returns right after the completing edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
endmodule

//--- sim/tb_csb_exec.sv
`timescale 1ns/10ps
module tb_csb_exec;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel, hwrite, hreadyout, hresp, exec_busy;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] pc_value;
  logic [7:0]  flag_value;
  logic [7:0]  dv [4] = '{8'h10, 8'h00, 8'h80, 8'h18};
  logic [7:0]  sv [4] = '{8'h10, 8'h01, 8'h01, 8'h09};
  logic [7:0]  fv [5] = '{8'h81, 8'h02, 8'h00, 8'h0F, 8'hA5};
  int          miscompares = 0;
  int          n_checks = 0;
  // 25 MHz core clock
  always #20 hclk = ~hclk;
  csb_ahb_host csb_ahb_host_i (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  csb_exec csb_exec_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .exec_busy(exec_busy),
    .pc_value(pc_value), .flag_value(flag_value));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    csb_ahb_host_i.xfer(1'b1, a, d, v);
  endtask
  // loads operands, runs one command, then checks against a local model
  task automatic run(input logic [4:0] op, input logic [31:0] opd, input logic [10:0] br,
                     input logic [7:0] f0);
    logic [7:0]  d, s, r, f;
    logic [15:0] pc;
    logic        tk, c;
    logic [1:0]  cy;
    d = opd[7:0];
    s = opd[15:8];
    f = f0;
    tk = 1'b0;
    cy = 2'h1;
    c = op == 5'h01 && f0[0];
    pc = 16'h0021;
    r = d - s - {7'h0, c};
    case (op)
      5'h00, 5'h01, 5'h02: begin
        f[0] = {1'b0, d} < {1'b0, s} + {8'h0, c};
        f[1] = r == 8'h00 && (op != 5'h01 || f0[1]);
        f[2] = r[7];
        f[3] = (d[7] & ~s[7] & ~r[7]) | (~d[7] & s[7] & r[7]);
        f[5] = (~d[3] & s[3]) | (s[3] & r[3]) | (r[3] & ~d[3]);
      end
      5'h03: tk = !s[opd[26:24]];
      5'h04: tk = s[opd[26:24]];
      5'h05: tk = !opd[16 + opd[26:24]];
      5'h06: tk = opd[16 + opd[26:24]];
      5'h07: tk = f0[br[10:8]];
      5'h08: tk = !f0[br[10:8]];
      5'h09: tk = f0[1];
      5'h0A: tk = !f0[1];
      5'h0B, 5'h0E: tk = f0[0];
      5'h0C, 5'h0D: tk = !f0[0];
      5'h0F: tk = f0[2];
      5'h10: tk = !f0[2];
      5'h11: tk = !(f0[2] ^ f0[3]);
      default: cy = 2'h1; // unknown code: only bad bit and the plain pc step
    endcase
    // skip step equals its cycle count; branch offset is signed
    if (tk && op < 5'h07) cy = opd[28] ? 2'h3 : 2'h2;
    if (tk && op < 5'h07) pc = 16'h0020 + {14'h0, cy};
    if (tk && op > 5'h06) cy = 2'h2;
    if (tk && op > 5'h06) pc = 16'h0021 + {{9{br[6]}}, br[6:0]};
    wr(csb_pkg::REG_OPERANDS, opd);
    wr(csb_pkg::REG_BRANCH, {21'h0, br});
    wr(csb_pkg::REG_PC, 32'h20);
    wr(csb_pkg::REG_FLAGS, {24'h0, f0});
    wr(csb_pkg::REG_COMMAND, {27'h0, op});
    csb_ahb_host_i.xfer(1'b0, csb_pkg::REG_COMMAND, 32'h0, v);
    chk({19'h0, v[12:0]}, {19'h0, op > 5'h11, cy, tk, 4'h0, op});
    csb_ahb_host_i.xfer(1'b0, csb_pkg::REG_PC, 32'h0, v);
    chk(v, {16'h0, pc});
    chk({16'h0, pc_value}, {16'h0, pc});
    chk({24'h0, flag_value}, {24'h0, f});
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    csb_ahb_host_i.xfer(1'b0, csb_pkg::REG_PC, 32'h0, v);
    chk(v, 32'h0);
    wr(8'h20, 32'h5A);
    csb_ahb_host_i.xfer(1'b0, 8'h20, 32'h0, v);
    chk(v, 32'h0);
    for (int i = 0; i < 4; i++)
      for (int op = 0; op < 3; op++)
        for (int j = 0; j < 2; j++)
          run(5'(op), {16'h0, sv[i], dv[i]}, 11'h0, fv[j]);
    for (int op = 3; op < 7; op++)
      for (int j = 0; j < 4; j++)
        run(5'(op), {3'h0, j[0], 4'h3, {2{j[1] ? 8'h08 : 8'hF7}}, 8'h0}, 11'h0, 8'h81);
    for (int op = 7; op < 18; op++)
      for (int j = 0; j < 10; j++)
        run(5'(op), 32'h0, {3'h2, 1'b0, j[0] ? 7'h40 : 7'h05}, fv[j / 2]);
    run(5'h12, 32'h0, 11'h0, 8'hA5);
    run(5'h1F, 32'h0, 11'h0, 8'h0F);
    summarize;
  end
  // hang guard, far beyond the expected run length
  initial begin
    #(40 * 20000);
    miscompares++;
    summarize;
  end
endmodule
